// >>> field_equipment.sv
/*
  Field side of the terminals: pulled-up open-collector line and
  two relay contacts. Assumes terminal levels 1 = on.
*/
`timescale 1ns/100ps

module field_equipment
(
   // Terminal levels
   input  wire logic y_out,
   input  wire logic relay_output_one,
   input  wire logic relay_output_two,
   // Field view
   output logic      y_line,
   output logic      ro1_closed,
   output logic      ro2_closed
);
   // Transistor on sinks the line, otherwise the pull-up wins
   assign y_line     = y_out ? 1'b0 : 1'b1;
   assign ro1_closed = relay_output_one;
   assign ro2_closed = relay_output_two;
endmodule

// >>> out_delay.sv
/*
  Switch-on / switch-off delay of one output terminal.
  Assumes a one-cycle millisecond tick on the same clock.
*/
`timescale 1ns/100ps
`include "out_sel_consts.svh"

module out_delay
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        resetn,
   // Timing
   input  wire logic        tick,
   input  wire logic [15:0] on_ms,
   input  wire logic [15:0] off_ms,
   // Level in and out
   input  wire logic        lvl,
   output logic             q
);

   out_sel_pkg::dly_state_type st_r;    // Registered state
   out_sel_pkg::dly_state_type st_nxt;  // Next state
   logic [15:0]                tgt;     // Delay of pending change

   // Pick delay for direction of change, count ms, then follow
   always_comb
   begin
      st_nxt = st_r;
      tgt    = lvl ? on_ms : off_ms;
      if (lvl == st_r.out)
      begin
         // Nothing pending
         st_nxt.cnt = 16'h0000;
      end
      else if (st_r.cnt >= tgt)
      begin
         // Delay spent, take the new level
         st_nxt.out = lvl; // R23
         st_nxt.cnt = 16'h0000;
      end
      else if (tick)
      begin
         // One more millisecond waited
         st_nxt.cnt = st_r.cnt + 16'h0001; // R23
      end
   end

   // State register
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         st_r <= '0;
      else
         st_r <= st_nxt;
   end

   assign q = st_r.out;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);

   // Output only ever moves to the requested level
   property p_follow;
      !$stable(st_r.out) |-> st_r.out == $past(lvl);
   endproperty
   a_follow: assert property (p_follow) // R23
      else $error("delay output moved away from input");

   // No change before the delay has run out
   property p_wait;
      (lvl != st_r.out) && (st_r.cnt < tgt) |=> $stable(st_r.out);
   endproperty
   a_wait: assert property (p_wait) // R23
      else $error("delay output changed early");

   // Change is taken once the delay is reached
   property p_take;
      (lvl != st_r.out) && (st_r.cnt >= tgt) |=> st_r.out == $past(lvl);
   endproperty
   a_take: assert property (p_take) // R23
      else $error("delay output missed its change");

endmodule

// >>> out_sel_consts.svh
/*
  Constants of the digital output selector: register byte offsets,
  reset values, delay limits and tick timing.
  Assumes a 100 MHz clock and a 32-bit classic Wishbone slave.
*/
`ifndef OUT_SEL_CONSTS_SVH
`define OUT_SEL_CONSTS_SVH

// Register byte offsets
`define OFF_SEL_Y      8'h00
`define OFF_SEL_RO1    8'h04
`define OFF_SEL_RO2    8'h08
`define OFF_POL        8'h0C
`define OFF_VOUT       8'h10
`define OFF_ON_Y       8'h14
`define OFF_OFF_Y      8'h18
`define OFF_ON_RO1     8'h1C
`define OFF_OFF_RO1    8'h20
`define OFF_ON_RO2     8'h24
`define OFF_OFF_RO2    8'h28
`define OFF_ANY_THR    8'h2C
`define OFF_ANY_TIME   8'h30
`define OFF_STATUS     8'h34

// Reset values
`define RST_SEL_Y      6'h00
`define RST_SEL_RO1    6'h01
`define RST_SEL_RO2    6'h05
`define RST_POL        4'h0
`define RST_ANY_THR    16'h0064
`define RST_ANY_TIME   16'h0005

// Polarity bit of each terminal
`define POL_BIT_Y      0
`define POL_BIT_RO1    2
`define POL_BIT_RO2    3

// Function codes
`define FC_VIRTUAL     6'h17
`define FC_UNUSED_21   6'h15

// Fault code of an external fault
`define EXT_FAULT_CODE 8'h11

// Timing
`define CLK_PERIOD_NS  10
`define MS_TICK_NS     1000000
`define MS_CYCLES      (`MS_TICK_NS / `CLK_PERIOD_NS)
`define MS_PER_DECI    7'h64
`define DLY_MAX_MS     16'hC350

`endif

// >>> out_sel_pkg.sv
/*
  Types of the digital output selector: drive status bundle and the
  state records of the selector and of the delay stage.
  Assumes nothing beyond the constants header.
*/
package out_sel_pkg;

   // Status conditions from the drive core, all on clk
   typedef struct packed {
      logic        running;         // Run command active
      logic        forward;         // Direction, 1 = forward
      logic        jogging;         // Jog operation
      logic        freq_nonzero;    // Output frequency above zero
      logic        ref_zero;        // Reference frequency zero
      logic        fault;           // Any fault present
      logic [7:0]  fault_code;      // Code of the active fault
      logic        freq_level_detector_one;
      logic        freq_level_detector_two;
      logic        freq_reached;    // Frequency reached detector
      logic        upper_lim;       // At upper limit frequency
      logic        lower_lim;       // At lower limit frequency
      logic        ready;           // Powers up, no protection
      logic        preexcite;       // Pre-excitation phase
      logic        overload_pre;    // Overload pre-alarm
      logic        underload_pre;   // Underload pre-alarm
      logic        stage_done;      // Sequencer stage complete
      logic        cycle_done;      // Sequencer cycle complete
      logic        count_en;        // Counting enabled
      logic        count_set_hit;   // Counter at set value
      logic        count_des_hit;   // Counter at designated value
      logic        run_time_hit;    // Single run time reached
      logic        bus_ok;          // Bus above undervoltage
      logic        sto_fault;       // Safe torque off fault
      logic [15:0] ramp_ref;        // Ramp reference, 0.01 Hz
   } drive_status_type;

   // Selector state
   typedef struct packed {
      logic [2:0][5:0]  sel;        // Function code per terminal
      logic [3:0]       pol;        // Polarity bits
      logic             vout;       // Virtual output value
      logic [2:0][15:0] on_ms;      // Switch-on delays, ms
      logic [2:0][15:0] off_ms;     // Switch-off delays, ms
      logic [15:0]      thr;        // Any-frequency threshold
      logic [15:0]      atime;      // Any-frequency time, 0.1 s
      logic             ack;        // Bus acknowledge
      logic [31:0]      rdat;       // Read data
      logic [31:0]      presc;      // Millisecond prescaler
      logic [6:0]       deci;       // Milliseconds in 0.1 s
      logic             tick;       // Millisecond pulse
      logic [15:0]      acnt;       // Time above threshold
      logic             any_hit;    // Any-frequency reached
   } sel_state_type;

   // Delay stage state
   typedef struct packed {
      logic        out;             // Delayed level
      logic [15:0] cnt;             // Elapsed ms of pending change
   } dly_state_type;

endpackage

// >>> out_selector.sv
/*
  Digital output selector: maps drive status conditions onto the
  open-collector output and two relay outputs, with per-terminal
  function code, polarity and switch-on/off delays, set over a
  classic Wishbone slave.
  Assumes all status inputs come from logic on clk.
*/
// Operation
// R1 - Three terminals, each with own function code
// R2 - Shared codes make terminals follow one source
// R3 - Code zero keeps terminal inactive
// R4 - Code 1: running with nonzero frequency
// R5 - Codes 2/3: forward or reverse frequency output
// R6 - Code 4: frequency output while jogging
// R7 - Code 5: any fault present
// R8 - Codes 6/7/8 pass detector outputs through
// R9 - Code 9: running, output and reference zero
// R10 - Codes 10/11: upper or lower limit reached
// R11 - Code 12: powered, unprotected, ready to run
// R12 - Code 13: pre-excitation phase
// R13 - Codes 14/15: overload or underload pre-alarm
// R14 - Codes 16/17: sequencer stage or cycle done
// R15 - Codes 18/19: counter hits, only when enabled
// R16 - Code 20: active fault is external fault
// R17 - Code 22: single run time reached
// R18 - Code 23: virtual output written by master
// R19 - Code 26: bus above undervoltage level
// R20 - Code 29: safe torque off fault active
// R21 - Code 37: ramp reference above threshold long enough
// R22 - Polarity bit inverts its terminal
// R23 - Separate switch-on and switch-off delays per terminal
// R24 - Unassigned codes behave like code zero
`timescale 1ns/100ps
`include "out_sel_consts.svh"

module out_selector
#(
   parameter int MS_CYCLES = `MS_CYCLES  // Clocks per millisecond
)
(
   // Clock and reset
   input  wire logic                         clk,
   input  wire logic                         resetn,
   // Classic Wishbone slave
   input  wire logic                         wb_cyc,
   input  wire logic                         wb_stb,
   input  wire logic                         wb_we,
   input  wire logic [7:0]                   wb_adr,
   input  wire logic [3:0]                   wb_sel,
   input  wire logic [31:0]                  wb_dat_w,
   output logic [31:0]                       wb_dat_r,
   output logic                              wb_ack,
   // Drive status conditions
   input  wire out_sel_pkg::drive_status_type ds,
   // Output terminals
   output logic                              y_out,
   output logic                              relay_output_one,
   output logic                              relay_output_two
);

   out_sel_pkg::sel_state_type st_r;    // Registered state
   out_sel_pkg::sel_state_type st_nxt;  // Next state
   logic [63:0]                src;     // Condition per code
   logic [2:0]                 lvl;     // Selected, polarised
   logic [2:0]                 q;       // Delayed terminal levels
   logic                       req;     // New bus request
   logic                       tenth;   // 100 ms pulse
   logic [3:0]                 pol_w;   // Written polarity bits
   logic [31:0]                cur;     // Addressed register value
   logic [31:0]                mw;      // Write merged under enables

   // Merge a write into a register under the byte enables
   function automatic logic [31:0] merge(input logic [31:0] o,
                                         input logic [31:0] n,
                                         input logic [3:0]  s);
      logic [31:0] r;
      r = o;
      for (int b = 0; b < 4; b++)
      begin
         if (s[b])
            r[8*b +: 8] = n[8*b +: 8];
      end
      return r;
   endfunction

   // Limit a delay to the settable range
   function automatic logic [15:0] clamp(input logic [31:0] v);
      if (v[15:0] > `DLY_MAX_MS || v[31:16] != 16'h0000)
         return `DLY_MAX_MS;
      else
         return v[15:0];
   endfunction

   // Polarity bit of a terminal
   function automatic logic pol_of(input logic [3:0] p,
                                   input int         t);
      case (t)
         0:       return p[`POL_BIT_Y];
         1:       return p[`POL_BIT_RO1];
         default: return p[`POL_BIT_RO2];
      endcase
   endfunction

   // Condition of one function code
   function automatic logic pick(input logic [63:0] v,
                                 input logic [5:0]  c);
      return v[c]; // R2
   endfunction

   assign req   = wb_cyc && wb_stb && !st_r.ack;
   assign tenth = st_r.tick && (st_r.deci == `MS_PER_DECI - 7'h01);
   assign pol_w = wb_dat_w[3:0];
   assign mw    = merge(cur, wb_dat_w, wb_sel);

   // Condition vector; unlisted codes stay zero
   always_comb
   begin
      src     = 64'h0000_0000_0000_0000; // R3 R24
      src[1]  = ds.running && ds.freq_nonzero; // R4
      src[2]  = ds.running && ds.freq_nonzero && ds.forward; // R5
      src[3]  = ds.running && ds.freq_nonzero && !ds.forward; // R5
      src[4]  = ds.jogging && ds.freq_nonzero; // R6
      src[5]  = ds.fault; // R7
      src[6]  = ds.freq_level_detector_one; // R8
      src[7]  = ds.freq_level_detector_two; // R8
      src[8]  = ds.freq_reached; // R8
      src[9]  = ds.running && !ds.freq_nonzero && ds.ref_zero; // R9
      src[10] = ds.upper_lim; // R10
      src[11] = ds.lower_lim; // R10
      src[12] = ds.ready; // R11
      src[13] = ds.preexcite; // R12
      src[14] = ds.overload_pre; // R13
      src[15] = ds.underload_pre; // R13
      src[16] = ds.stage_done; // R14
      src[17] = ds.cycle_done; // R14
      src[18] = ds.count_en && ds.count_set_hit; // R15
      src[19] = ds.count_en && ds.count_des_hit; // R15
      src[20] = ds.fault && ds.fault_code == `EXT_FAULT_CODE; // R16
      src[22] = ds.run_time_hit; // R17
      src[23] = st_r.vout; // R18
      src[26] = ds.bus_ok; // R19
      src[29] = ds.sto_fault; // R20
      src[37] = st_r.any_hit; // R21
   end

   // Per-terminal selection and polarity
   always_comb
   begin
      for (int t = 0; t < 3; t++)
      begin
         lvl[t] = pick(src, st_r.sel[t]) ^ pol_of(st_r.pol, t); // R1 R22
      end
   end

   // Value of the addressed register, unmapped places read zero
   always_comb
   begin
      case (wb_adr)
         `OFF_SEL_Y:    cur = 32'(st_r.sel[0]);
         `OFF_SEL_RO1:  cur = 32'(st_r.sel[1]);
         `OFF_SEL_RO2:  cur = 32'(st_r.sel[2]);
         `OFF_POL:      cur = 32'(st_r.pol);
         `OFF_VOUT:     cur = 32'(st_r.vout);
         `OFF_ON_Y:     cur = 32'(st_r.on_ms[0]);
         `OFF_OFF_Y:    cur = 32'(st_r.off_ms[0]);
         `OFF_ON_RO1:   cur = 32'(st_r.on_ms[1]);
         `OFF_OFF_RO1:  cur = 32'(st_r.off_ms[1]);
         `OFF_ON_RO2:   cur = 32'(st_r.on_ms[2]);
         `OFF_OFF_RO2:  cur = 32'(st_r.off_ms[2]);
         `OFF_ANY_THR:  cur = 32'(st_r.thr);
         `OFF_ANY_TIME: cur = 32'(st_r.atime);
         `OFF_STATUS:   cur = {21'h0, lvl, 4'h0, q[2], q[1], 1'b0,
                              q[0]};
         default:       cur = 32'h0000_0000;
      endcase
   end

   // Register file, timers and any-frequency detector
   always_comb
   begin
      st_nxt      = st_r;
      st_nxt.ack  = req;
      st_nxt.tick = 1'b0;
      // Millisecond prescaler
      if (st_r.presc >= 32'(MS_CYCLES - 1))
      begin
         st_nxt.presc = 32'h0000_0000;
         st_nxt.tick  = 1'b1;
      end
      else
      begin
         st_nxt.presc = st_r.presc + 32'h0000_0001;
      end
      // Tenths of a second, phase restarts at or below threshold
      if (tenth || ds.ramp_ref <= st_r.thr)
         st_nxt.deci = 7'h00; // R21
      else if (st_r.tick)
         st_nxt.deci = st_r.deci + 7'h01;
      // Time spent above the threshold, restarts at or below it
      if (ds.ramp_ref <= st_r.thr)
         st_nxt.acnt = 16'h0000; // R21
      else if (tenth && st_r.acnt != 16'hFFFF)
         st_nxt.acnt = st_r.acnt + 16'h0001; // R21
      st_nxt.any_hit = (ds.ramp_ref > st_r.thr) &&
                       (st_nxt.acnt >= st_r.atime); // R21
      // Register writes, merged under the byte enables
      if (req && wb_we)
      begin
         case (wb_adr)
            `OFF_SEL_Y:    st_nxt.sel[0]    = mw[5:0]; // R1
            `OFF_SEL_RO1:  st_nxt.sel[1]    = mw[5:0]; // R1
            `OFF_SEL_RO2:  st_nxt.sel[2]    = mw[5:0]; // R1
            `OFF_POL:      st_nxt.pol       = mw[3:0]; // R22
            `OFF_VOUT:     st_nxt.vout      = mw[0]; // R18
            `OFF_ON_Y:     st_nxt.on_ms[0]  = clamp(mw); // R23
            `OFF_OFF_Y:    st_nxt.off_ms[0] = clamp(mw); // R23
            `OFF_ON_RO1:   st_nxt.on_ms[1]  = clamp(mw); // R23
            `OFF_OFF_RO1:  st_nxt.off_ms[1] = clamp(mw); // R23
            `OFF_ON_RO2:   st_nxt.on_ms[2]  = clamp(mw); // R23
            `OFF_OFF_RO2:  st_nxt.off_ms[2] = clamp(mw); // R23
            `OFF_ANY_THR:  st_nxt.thr       = mw[15:0]; // R21
            `OFF_ANY_TIME: st_nxt.atime     = mw[15:0]; // R21
            default:       st_nxt.vout      = st_r.vout; // Ignored
         endcase
      end
      // Register reads take the addressed value
      if (req && !wb_we)
         st_nxt.rdat = cur;
   end

   // State register with documented defaults
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         st_r        <= '0;
         st_r.sel[0] <= `RST_SEL_Y;
         st_r.sel[1] <= `RST_SEL_RO1;
         st_r.sel[2] <= `RST_SEL_RO2;
         st_r.pol    <= `RST_POL;
         st_r.thr    <= `RST_ANY_THR;
         st_r.atime  <= `RST_ANY_TIME;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   // One delay stage per terminal
   for (genvar t = 0; t < 3; t++)
   begin : g_dly
      out_delay u_dly
      (
         .clk    (clk),
         .resetn (resetn),
         .tick   (st_r.tick),
         .on_ms  (st_r.on_ms[t]),
         .off_ms (st_r.off_ms[t]),
         .lvl    (lvl[t]),
         .q      (q[t])
      );
   end

   // Outputs
   assign wb_ack           = st_r.ack;
   assign wb_dat_r         = st_r.rdat;
   assign y_out            = q[0];
   assign relay_output_one = q[1];
   assign relay_output_two = q[2];

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);

   // Bus answers one cycle after the request, for one cycle
   property p_ack;
      req |=> wb_ack ##1 !wb_ack;
   endproperty
   a_ack: assert property (p_ack)
      else $error("bus acknowledge timing wrong");

   // Code zero gives polarity level only
   property p_zero;
      st_r.sel[1] == 6'h00 |-> lvl[1] == st_r.pol[`POL_BIT_RO1];
   endproperty
   a_zero: assert property (p_zero) // R3
      else $error("code zero terminal not inactive");

   // Running with frequency
   property p_run;
      st_r.sel[0] == 6'h01 |->
         lvl[0] == ((ds.running && ds.freq_nonzero) ^ st_r.pol[0]);
   endproperty
   a_run: assert property (p_run) // R4
      else $error("running code wrong");

   // Reverse direction
   property p_rev;
      st_r.sel[2] == 6'h03 && !st_r.pol[3] |-> lvl[2] ==
         (ds.running && ds.freq_nonzero && !ds.forward);
   endproperty
   a_rev: assert property (p_rev) // R5
      else $error("reverse code wrong");

   // Fault with the external fault code
   property p_ext;
      st_r.sel[0] == 6'h14 && !st_r.pol[0] |-> lvl[0] ==
         (ds.fault && ds.fault_code == `EXT_FAULT_CODE);
   endproperty
   a_ext: assert property (p_ext) // R16
      else $error("external fault code wrong");

   // Counter hit masked when counting off
   property p_cnt;
      st_r.sel[1] == 6'h12 && !ds.count_en |->
         lvl[1] == st_r.pol[`POL_BIT_RO1];
   endproperty
   a_cnt: assert property (p_cnt) // R15
      else $error("counter hit while counting disabled");

   // Unassigned code stays inactive
   property p_gap;
      st_r.sel[2] == `FC_UNUSED_21 |-> lvl[2] == st_r.pol[3];
   endproperty
   a_gap: assert property (p_gap) // R24
      else $error("unassigned code drove terminal");

   // Same code on two terminals follows one source
   property p_share;
      st_r.sel[0] == st_r.sel[2] |->
         (lvl[0] ^ st_r.pol[0]) == (lvl[2] ^ st_r.pol[3]);
   endproperty
   a_share: assert property (p_share) // R2
      else $error("terminals with same code differ");

   // Virtual output written then shown
   sequence s_wr_vout;
      req && wb_we && wb_adr == `OFF_VOUT && wb_sel[0];
   endsequence
   property p_vout;
      s_wr_vout ##1 st_r.sel[0] == `FC_VIRTUAL && !st_r.pol[0]
         |-> lvl[0] == $past(wb_dat_w[0]);
   endproperty
   a_vout: assert property (p_vout) // R18
      else $error("virtual output not followed");

   // Polarity write lands in the register
   sequence s_wr_pol;
      req && wb_we && wb_adr == `OFF_POL && wb_sel[0];
   endsequence
   property p_pol;
      s_wr_pol |=> st_r.pol == $past(pol_w);
   endproperty
   a_pol: assert property (p_pol) // R22
      else $error("polarity write lost");

   // Any-frequency hit only when above threshold
   property p_any;
      $rose(st_r.any_hit) |-> $past(ds.ramp_ref) > $past(st_r.thr);
   endproperty
   a_any: assert property (p_any) // R21
      else $error("any-frequency asserted below threshold");

endmodule

// >>> test_drive_digital_output_selector.sv
/*
  Bench of the output selector: code table, polarity, delays,
  virtual output, any-frequency timer and registers.
  Assumes MS_CYCLES of 10 and the field model beside the design.
*/
`timescale 1ns/100ps
`include "out_sel_consts.svh"

module test_drive_digital_output_selector;
   typedef struct packed
   {
      logic [5:0] code;  // Function code
      logic [7:0] kill;  // Status bit cleared, FF none
      logic       exp;   // Expected terminal level
   } row_type;
   logic        clk, resetn, wb_cyc, wb_stb, wb_we, wb_ack;
   logic        y_out, relay_output_one, relay_output_two;
   logic        y_line, ro1_closed, ro2_closed;
   logic [7:0]  wb_adr;
   logic [3:0]  wb_sel;
   logic [31:0] wb_dat_w, wb_dat_r, rd, outs, x, st;
   out_sel_pkg::drive_status_type ds;
   int          fails, checked, cycles;
   row_type     rows [33];

   // Terminals and the field side, packed for one compare
   assign outs = {28'h0, y_out, relay_output_one, relay_output_two,
                  ~y_line};

   out_selector #(.MS_CYCLES(10)) out_selector_inst
   (
      .clk(clk), .resetn(resetn), .wb_cyc(wb_cyc), .wb_stb(wb_stb),
      .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel),
      .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r), .wb_ack(wb_ack),
      .ds(ds), .y_out(y_out), .relay_output_one(relay_output_one),
      .relay_output_two(relay_output_two)
   );
   field_equipment field_equipment_inst
   (
      .y_out(y_out), .relay_output_one(relay_output_one),
      .relay_output_two(relay_output_two), .y_line(y_line),
      .ro1_closed(ro1_closed), .ro2_closed(ro2_closed)
   );

   // Status that makes a code true; unknown codes get everything
   function automatic out_sel_pkg::drive_status_type src(row_type r);
      out_sel_pkg::drive_status_type s;
      s = '0;
      case (r.code)
         6'h01, 6'h03: {s.running, s.freq_nonzero} = 2'h3;
         6'h02: {s.running, s.freq_nonzero, s.forward} = 3'h7;
         6'h04: {s.running, s.freq_nonzero, s.jogging} = 3'h7;
         6'h05: s.fault = 1'b1;
         6'h06: s.freq_level_detector_one = 1'b1;
         6'h07: s.freq_level_detector_two = 1'b1;
         6'h08: s.freq_reached = 1'b1;
         6'h09: {s.running, s.ref_zero} = 2'h3;
         6'h0A: s.upper_lim = 1'b1;
         6'h0B: s.lower_lim = 1'b1;
         6'h0C: s.ready = 1'b1;
         6'h0D: s.preexcite = 1'b1;
         6'h0E: s.overload_pre = 1'b1;
         6'h0F: s.underload_pre = 1'b1;
         6'h10: s.stage_done = 1'b1;
         6'h11: s.cycle_done = 1'b1;
         6'h12: {s.count_en, s.count_set_hit} = 2'h3;
         6'h13: {s.count_en, s.count_des_hit} = 2'h3;
         6'h14: {s.fault, s.fault_code} = {1'b1, `EXT_FAULT_CODE};
         6'h16: s.run_time_hit = 1'b1;
         6'h1A: s.bus_ok = 1'b1;
         6'h1D: s.sto_fault = 1'b1;
         default: s = '1;
      endcase
      if (r.kill != 8'hFF)
         s[r.kill] = 1'b0;
      return s;
   endfunction

   // Compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] e);
      checked++;
      if (got !== e)
      begin
         fails++;
         $display("ERROR at %0t: got %h expected %h", $time, got, e);
      end
   endtask

   // One classic Wishbone cycle, held until ack is sampled
   task automatic wb(input logic we, input logic [7:0] a,
                     input logic [31:0] d);
      wb_cyc   <= 1'b1;
      wb_stb   <= 1'b1;
      wb_we    <= we;
      wb_adr   <= a;
      wb_sel   <= 4'hF;
      wb_dat_w <= d;
      do
         @(posedge clk);
      while (wb_ack !== 1'b1);
      rd = wb_dat_r;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      wb_we  <= 1'b0;
      @(posedge clk);
   endtask

   // Same code on all three terminals
   task automatic set_all(input logic [5:0] c);
      wb(1'b1, `OFF_SEL_Y, {26'h0, c});
      wb(1'b1, `OFF_SEL_RO1, {26'h0, c});
      wb(1'b1, `OFF_SEL_RO2, {26'h0, c});
   endtask

   task automatic final_report;
      $display("Counts: %0d checked, %0d failed", checked, fails);
      if (fails == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // Clock, 10 ns period
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Cut a hang short
   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         fails++;
         final_report();
      end
   end

   // Main sequence
   initial
   begin
      {resetn, wb_cyc, wb_stb, wb_we, wb_adr, wb_sel, wb_dat_w} = '0;
      ds = '0;
      {fails, checked, cycles} = '0;
      rows = '{'{6'h01,8'hFF,1'h1}, '{6'h02,8'hFF,1'h1},
         '{6'h03,8'hFF,1'h1}, '{6'h04,8'hFF,1'h1}, '{6'h05,8'hFF,1'h1},
         '{6'h06,8'hFF,1'h1}, '{6'h07,8'hFF,1'h1}, '{6'h08,8'hFF,1'h1},
         '{6'h09,8'hFF,1'h1}, '{6'h0A,8'hFF,1'h1}, '{6'h0B,8'hFF,1'h1},
         '{6'h0C,8'hFF,1'h1}, '{6'h0D,8'hFF,1'h1}, '{6'h0E,8'hFF,1'h1},
         '{6'h0F,8'hFF,1'h1}, '{6'h10,8'hFF,1'h1}, '{6'h11,8'hFF,1'h1},
         '{6'h12,8'hFF,1'h1}, '{6'h13,8'hFF,1'h1}, '{6'h14,8'hFF,1'h1},
         '{6'h16,8'hFF,1'h1}, '{6'h1A,8'hFF,1'h1}, '{6'h1D,8'hFF,1'h1},
         '{6'h01,8'h2B,1'h0}, '{6'h02,8'h2D,1'h0}, '{6'h09,8'h2E,1'h0},
         '{6'h12,8'h15,1'h0}, '{6'h14,8'h21,1'h0}, '{6'h00,8'hFF,1'h0},
         '{6'h15,8'hFF,1'h0}, '{6'h18,8'hFF,1'h0}, '{6'h19,8'hFF,1'h0},
         '{6'h3F,8'hFF,1'h0}};
      repeat (4) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      // Defaults and an unmapped place
      wb(1'b0, `OFF_SEL_RO2, 32'h0);
      chk(rd, 32'h00000005);
      wb(1'b0, 8'h3C, 32'h0);
      chk(rd, 32'h00000000);
      $display("test registers done");
      // Table of codes: terminals and the selected levels
      foreach (rows[i])
      begin
         set_all(rows[i].code);
         ds <= src(rows[i]);
         repeat (4) @(posedge clk);
         x  = {28'h0, {4{rows[i].exp}}};
         st = {21'h0, {3{rows[i].exp}}, 4'h0, {2{rows[i].exp}}, 1'b0,
               rows[i].exp};
         chk(outs, x);
         wb(1'b0, `OFF_STATUS, 32'h0);
         chk(rd, st);
      end
      $display("test codes done");
      // Polarity on Y and RO2 only, status quiet again
      ds <= '0;
      set_all(6'h00);
      wb(1'b1, `OFF_POL, 32'h00000009);
      repeat (4) @(posedge clk);
      chk(outs, 32'h0000000B);
      wb(1'b1, `OFF_POL, 32'h00000000);
      // Virtual terminal on and off
      set_all(`FC_VIRTUAL);
      wb(1'b1, `OFF_VOUT, 32'h00000001);
      repeat (4) @(posedge clk);
      chk(outs, 32'h0000000F);
      wb(1'b1, `OFF_VOUT, 32'h00000000);
      repeat (4) @(posedge clk);
      chk(outs, 32'h00000000);
      $display("test polarity and virtual done");
      // RO1 with 3 ms on and 2 ms off; Y follows at once
      set_all(6'h05);
      wb(1'b1, `OFF_ON_RO1, 32'h00000003);
      wb(1'b1, `OFF_OFF_RO1, 32'h00000002);
      ds.fault <= 1'b1;
      repeat (20) @(posedge clk);
      chk(outs, 32'h0000000B);
      repeat (20) @(posedge clk);
      chk(outs, 32'h0000000F);
      ds.fault <= 1'b0;
      repeat (10) @(posedge clk);
      chk(outs, 32'h00000004);
      repeat (20) @(posedge clk);
      chk(outs, 32'h00000000);
      wb(1'b1, `OFF_ON_Y, 32'h0000FFFF);
      wb(1'b0, `OFF_ON_Y, 32'h0);
      chk(rd, 32'h0000C350);
      $display("test delays done");
      // Any frequency: equal to threshold stays off, above for 0.2 s
      set_all(6'h25);
      wb(1'b1, `OFF_ANY_TIME, 32'h00000002);
      ds.ramp_ref <= 16'h0064;
      repeat (2100) @(posedge clk);
      chk({31'h0, relay_output_two}, 32'h0);
      ds.ramp_ref <= 16'h0065;
      repeat (1900) @(posedge clk);
      chk({31'h0, relay_output_two}, 32'h0);
      repeat (200) @(posedge clk);
      chk({31'h0, relay_output_two}, 32'h1);
      $display("test any frequency done");
      final_report();
   end
endmodule
